// ==== include/wt_timer_map.vh ====
`ifndef WT_TIMER_MAP_VH
`define WT_TIMER_MAP_VH
// register addresses
`define WT_ADDR_T0_CTRL 8'hd2
`define WT_ADDR_BT_CTRL 8'hd3
`define WT_ADDR_BT_COUNT 8'hfd
`define WT_ADDR_T0_REF 8'hd1
`define WT_ADDR_T0_COUNT 8'hd0
`define WT_ADDR_P3_CTRL 8'hef
// reset values
`define WT_RST_T0_CTRL 8'h00
`define WT_RST_BT_CTRL 8'h00
`define WT_RST_P3_CTRL 8'h00
// basic timer control fields
`define WT_BT_WD_OFF_CODE 4'ha
`define WT_BT_CLR_DIV_BIT 0
`define WT_BT_CLR_CNT_BIT 1
`define WT_BT_SEL_4096 2'b00
`define WT_BT_SEL_1024 2'b01
`define WT_BT_SEL_128 2'b10
`define WT_BT_SEL_16384 2'b11
// timer 0 control fields
`define WT_T0_PEND_BIT 0
`define WT_T0_MIE_BIT 1
`define WT_T0_OIE_BIT 2
`define WT_T0_CLR_BIT 3
`define WT_T0_MODE_INTERVAL 2'b00
`define WT_T0_MODE_CAP_RISE 2'b01
`define WT_T0_MODE_CAP_FALL 2'b10
`define WT_T0_MODE_PWM 2'b11
`define WT_T0_SEL_4096 2'b00
`define WT_T0_SEL_256 2'b01
`define WT_T0_SEL_8 2'b10
`define WT_T0_SEL_EXT 2'b11
`define WT_P3_CAP_SEL_BIT 2
// interrupt vectors
`define WT_VEC_T0_OVF 8'hfa
`define WT_VEC_T0_MATCH 8'hfc
// divider tap masks (divide by mask + 1)
`define WT_MASK_16384 14'h3fff
`define WT_MASK_4096 14'h0fff
`define WT_MASK_1024 14'h03ff
`define WT_MASK_256 14'h00ff
`define WT_MASK_128 14'h007f
`define WT_MASK_8 14'h0007
`endif

// ==== hw/wt_timer.v ====
// Function
// - reset clears basic control, watchdog on, div4096
// - watchdog off only with upper nibble 1010
// - basic counter overflow with watchdog on resets
// - writing bit 1 clears basic counter
// - stop release restarts oscillator, selects stabilization rate
// - cpu clock gated until counter bit 3 overflows
// - reset clears timer0 control: interval, div4096, irqs off
// - writing bit 3 clears timer0 counter
// - overflow irq, vector FA, cleared on service
// - bit 1 enables match irq, vector FC
// - bit 0 shows match pending, software clears
// - interval match raises irq, clears counter
// - interval match toggles output pin
// - pwm counter wraps freely, match no clear
// - pwm out low while ref <= counter
// - capture edge loads counter into reference
// - port3 bit 2 routes pin to capture
// - capture mode raises overflow and capture irqs
// - basic prescaler 16384/4096/1024/128, counter read-only
// - timer0 clock div 4096/256/8 or external
`timescale 1ns/1ps
`default_nettype none
`include "wt_timer_map.vh"

module wt_timer (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire stop_enter,
  input wire stop_release_reset,
  input wire stop_release_ext,
  output wire osc_enable,
  output wire cpu_clock_enable,
  output reg watchdog_reset,
  input wire timer0_ext_clock_in,
  input wire timer0_capture_in,
  output reg timer0_pwm_out,
  output wire timer0_overflow_irq,
  input wire timer0_overflow_ack,
  output wire timer0_match_capture_irq,
  output wire [7:0] timer0_overflow_vector,
  output wire [7:0] timer0_match_vector
);

  ////////////////////////////////////////////////////////////////
  // register state
  reg [7:0] bt_ctrl_reg; // basic timer control, bits 1:0 unused
  reg [7:0] bt_cnt_reg; // basic timer counter
  reg [13:0] bt_div_reg; // basic timer prescaler
  reg [7:0] t0_ctrl_reg; // timer0 control
  reg [7:0] t0_cnt_reg; // timer0 counter
  reg [7:0] t0_ref_reg; // timer0 reference / capture data
  reg [11:0] t0_div_reg; // timer0 prescaler
  reg [7:0] p3_ctrl_reg; // port3 control, only capture select used
  reg t0_ovf_pend_reg; // overflow pending
  reg ext_prev_reg; // previous external clock level
  reg cap_prev_reg; // previous capture pin level
  reg stop_reg; // oscillator stopped
  reg stab_reg; // stabilization in progress
  reg stab_fixed_reg; // stabilization at fixed div4096 rate

  ////////////////////////////////////////////////////////////////
  // write decode
  wire wr_bt = reg_wr && (reg_addr == `WT_ADDR_BT_CTRL);
  wire wr_t0 = reg_wr && (reg_addr == `WT_ADDR_T0_CTRL);
  wire wr_ref = reg_wr && (reg_addr == `WT_ADDR_T0_REF);
  wire wr_p3 = reg_wr && (reg_addr == `WT_ADDR_P3_CTRL);

  ////////////////////////////////////////////////////////////////
  // basic timer clock select
  wire [1:0] bt_sel = bt_ctrl_reg[3:2];
  // stabilization after reset release forces div4096
  wire [1:0] bt_sel_eff = (stab_reg && stab_fixed_reg) ? `WT_BT_SEL_4096 : bt_sel;
  reg [13:0] bt_mask;

  // tap mask for the selected basic timer rate
  always @* begin
    bt_mask = `WT_MASK_4096;
    case (bt_sel_eff)
      `WT_BT_SEL_1024: bt_mask = `WT_MASK_1024;
      `WT_BT_SEL_128: bt_mask = `WT_MASK_128;
      `WT_BT_SEL_16384: bt_mask = `WT_MASK_16384;
      default: bt_mask = `WT_MASK_4096;
    endcase
  end

  // prescaler frozen while the oscillator is stopped
  wire bt_tick = !stop_reg && ((bt_div_reg & bt_mask) == bt_mask);
  wire wd_enable = (bt_ctrl_reg[7:4] != `WT_BT_WD_OFF_CODE);
  wire bt_wrap = bt_tick && (bt_cnt_reg == 8'hff);
  wire bt_bit3_ovf = bt_tick && (bt_cnt_reg[3:0] == 4'hf);

  assign osc_enable = !stop_reg;
  assign cpu_clock_enable = !stop_reg && !stab_reg;

  ////////////////////////////////////////////////////////////////
  // basic timer control register, clear bits 1:0 read back zero
  always @(posedge clk) begin
    if (sys_rst) begin
      bt_ctrl_reg <= `WT_RST_BT_CTRL;
    end else if (wr_bt) begin
      bt_ctrl_reg <= {reg_wdata[7:2], 2'b00};
    end
  end

  // basic timer prescaler
  always @(posedge clk) begin
    if (sys_rst) begin
      bt_div_reg <= 14'h0000;
    end else if (wr_bt && reg_wdata[`WT_BT_CLR_DIV_BIT]) begin
      bt_div_reg <= 14'h0000;
    end else if (!stop_reg) begin
      bt_div_reg <= bt_div_reg + 14'h0001;
    end
  end

  // basic timer counter; software only clears it
  always @(posedge clk) begin
    if (sys_rst) begin
      bt_cnt_reg <= 8'h00;
    end else if (stop_reg && (stop_release_reset || stop_release_ext)) begin
      // gated by stop so a stray release pulse cannot feed the watchdog
      bt_cnt_reg <= 8'h00;
    end else if (wr_bt && reg_wdata[`WT_BT_CLR_CNT_BIT]) begin
      bt_cnt_reg <= 8'h00;
    end else if (bt_tick) begin
      bt_cnt_reg <= bt_cnt_reg + 8'h01;
    end
  end

  // watchdog reset pulse; held off during stabilization
  always @(posedge clk) begin
    if (sys_rst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= bt_wrap && wd_enable && !stab_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // stop mode and oscillation stabilization
  always @(posedge clk) begin
    if (sys_rst) begin
      stop_reg <= 1'b0;
      stab_reg <= 1'b0;
      stab_fixed_reg <= 1'b0;
    end else if (stop_reg && (stop_release_reset || stop_release_ext)) begin
      // oscillator restarts, cpu waits for counter bit 3
      stop_reg <= 1'b0;
      stab_reg <= 1'b1;
      stab_fixed_reg <= stop_release_reset;
    end else if (stab_reg && bt_bit3_ovf) begin
      stab_reg <= 1'b0;
    end else if (stop_enter && !stab_reg) begin
      stop_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // timer0 clock select
  wire [1:0] t0_sel = t0_ctrl_reg[7:6];
  wire [1:0] t0_mode = t0_ctrl_reg[5:4];
  wire t0_ext_edge = timer0_ext_clock_in && !ext_prev_reg;
  reg t0_tick;

  // one enable pulse per timer0 clock
  always @* begin
    t0_tick = 1'b0;
    case (t0_sel)
      `WT_T0_SEL_256: t0_tick = ({6'h00, t0_div_reg[7:0]} == `WT_MASK_256);
      `WT_T0_SEL_8: t0_tick = ({11'h000, t0_div_reg[2:0]} == `WT_MASK_8);
      `WT_T0_SEL_EXT: t0_tick = t0_ext_edge;
      default: t0_tick = ({2'b00, t0_div_reg} == `WT_MASK_4096);
    endcase
  end

  // mode decode; edge select lives in the mode field
  wire mode_pwm = (t0_mode == `WT_T0_MODE_PWM);
  wire mode_cap = (t0_mode == `WT_T0_MODE_CAP_RISE) || (t0_mode == `WT_T0_MODE_CAP_FALL);
  wire mode_int = (t0_mode == `WT_T0_MODE_INTERVAL);
  wire cap_pin = p3_ctrl_reg[`WT_P3_CAP_SEL_BIT] && timer0_capture_in;
  wire cap_rise = cap_pin && !cap_prev_reg;
  wire cap_fall = !cap_pin && cap_prev_reg;
  wire cap_edge = (t0_mode == `WT_T0_MODE_CAP_RISE) ? cap_rise : cap_fall;
  wire cap_event = mode_cap && cap_edge;
  wire t0_clr = wr_t0 && reg_wdata[`WT_T0_CLR_BIT];
  wire t0_match = t0_tick && (t0_cnt_reg == t0_ref_reg);
  wire t0_wrap = t0_tick && (t0_cnt_reg == 8'hff) && !(mode_int && t0_match);
  // match in interval/pwm, load in capture
  wire t0_mc_set = cap_event || (t0_match && !mode_cap);

  ////////////////////////////////////////////////////////////////
  // timer0 prescaler and edge history
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_div_reg <= 12'h000;
      ext_prev_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      t0_div_reg <= t0_div_reg + 12'h001;
      ext_prev_reg <= timer0_ext_clock_in;
      cap_prev_reg <= cap_pin;
    end
  end

  // timer0 counter
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_cnt_reg <= 8'h00;
    end else if (t0_clr) begin
      t0_cnt_reg <= 8'h00;
    end else if (t0_tick) begin
      if (mode_int && t0_match) begin
        t0_cnt_reg <= 8'h00;
      end else begin
        t0_cnt_reg <= t0_cnt_reg + 8'h01;
      end
    end
  end

  // reference register; a capture beats a software write
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_ref_reg <= 8'hff;
    end else if (cap_event) begin
      t0_ref_reg <= t0_cnt_reg;
    end else if (wr_ref) begin
      t0_ref_reg <= reg_wdata;
    end
  end

  // timer0 control; pending set wins over a clearing write
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_ctrl_reg <= `WT_RST_T0_CTRL;
    end else begin
      if (wr_t0) begin
        t0_ctrl_reg[7:1] <= {reg_wdata[7:4], 1'b0, reg_wdata[2:1]};
      end
      if (t0_mc_set) begin
        t0_ctrl_reg[`WT_T0_PEND_BIT] <= 1'b1;
      end else if (wr_t0 && !reg_wdata[`WT_T0_PEND_BIT]) begin
        t0_ctrl_reg[`WT_T0_PEND_BIT] <= 1'b0;
      end
    end
  end

  // overflow pending, cleared by the service acknowledge
  always @(posedge clk) begin
    if (sys_rst) begin
      t0_ovf_pend_reg <= 1'b0;
    end else if (t0_wrap) begin
      t0_ovf_pend_reg <= 1'b1;
    end else if (timer0_overflow_ack) begin
      t0_ovf_pend_reg <= 1'b0;
    end
  end

  assign timer0_overflow_irq = t0_ovf_pend_reg && t0_ctrl_reg[`WT_T0_OIE_BIT];
  assign timer0_match_capture_irq = t0_ctrl_reg[`WT_T0_PEND_BIT] &&
                                    t0_ctrl_reg[`WT_T0_MIE_BIT];
  assign timer0_overflow_vector = `WT_VEC_T0_OVF;
  assign timer0_match_vector = `WT_VEC_T0_MATCH;

  ////////////////////////////////////////////////////////////////
  // timer0 output pin
  always @(posedge clk) begin
    if (sys_rst) begin
      timer0_pwm_out <= 1'b0;
    end else if (mode_pwm) begin
      timer0_pwm_out <= (t0_ref_reg > t0_cnt_reg);
    end else if (mode_int && t0_match) begin
      timer0_pwm_out <= !timer0_pwm_out;
    end
  end

  ////////////////////////////////////////////////////////////////
  // port3 control, only the capture route bit acts here
  always @(posedge clk) begin
    if (sys_rst) begin
      p3_ctrl_reg <= `WT_RST_P3_CTRL;
    end else if (wr_p3) begin
      p3_ctrl_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped reads zero
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `WT_ADDR_BT_CTRL) begin
        reg_rdata <= bt_ctrl_reg;
      end else if (reg_addr == `WT_ADDR_BT_COUNT) begin
        reg_rdata <= bt_cnt_reg;
      end else if (reg_addr == `WT_ADDR_T0_CTRL) begin
        reg_rdata <= t0_ctrl_reg;
      end else if (reg_addr == `WT_ADDR_T0_COUNT) begin
        reg_rdata <= t0_cnt_reg;
      end else if (reg_addr == `WT_ADDR_T0_REF) begin
        reg_rdata <= t0_ref_reg;
      end else if (reg_addr == `WT_ADDR_P3_CTRL) begin
        reg_rdata <= p3_ctrl_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/wt_timer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module wt_timer_chk (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire stop_enter,
  input wire stop_release_reset,
  input wire stop_release_ext,
  input wire osc_enable,
  input wire cpu_clock_enable,
  input wire watchdog_reset,
  input wire timer0_pwm_out,
  input wire timer0_overflow_irq,
  input wire timer0_overflow_ack,
  input wire timer0_match_capture_irq,
  input wire [7:0] timer0_overflow_vector,
  input wire [7:0] timer0_match_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // write to the timer 0 control address
  wire t0_wr = reg_wr && (reg_addr == 8'hd2);
  // any stop release request
  wire rel = stop_release_reset || stop_release_ext;
  ////////////////////////////////////////////////////////////////////////////////
  AST_RST: assert property (disable iff (1'b0) sys_rst |=>
    !watchdog_reset && !timer0_pwm_out && osc_enable && cpu_clock_enable
    && !timer0_overflow_irq && !timer0_match_capture_irq) else $error("reset outputs");
  AST_VEC: assert property (
    timer0_overflow_vector == 8'hfa && timer0_match_vector == 8'hfc) else $error("vectors");
  AST_WD_PULSE: assert property (
    watchdog_reset |=> !watchdog_reset) else $error("watchdog pulse too long");
  AST_OVF_ACK: assert property (
    timer0_overflow_ack |=> !timer0_overflow_irq) else $error("overflow not cleared");
  AST_OIE_OFF: assert property (
    t0_wr && !reg_wdata[2] |=> !timer0_overflow_irq) else $error("overflow irq masked");
  AST_MIE_OFF: assert property (
    t0_wr && !reg_wdata[1] |=> !timer0_match_capture_irq) else $error("match irq masked");
  AST_STOP: assert property (
    stop_enter && osc_enable && cpu_clock_enable && !rel |=> !osc_enable && !cpu_clock_enable)
    else $error("stop not entered");
  AST_HOLD: assert property (
    !osc_enable && !rel |=> !osc_enable) else $error("oscillator restarted alone");
  AST_REL: assert property (
    !osc_enable && rel |=> (osc_enable && !cpu_clock_enable) [*8]) else $error("release");
  AST_STAB: assert property (
    $rose(cpu_clock_enable) && !$past(sys_rst) |-> $past(cpu_clock_enable, 16) == 1'b0)
    else $error("stabilization too short");
  // main scenarios reached
  cover property ($rose(watchdog_reset));
  cover property ($rose(cpu_clock_enable));
  cover property (timer0_overflow_ack && timer0_overflow_irq);
endmodule
bind wt_timer wt_timer_chk wt_timer_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .stop_enter(stop_enter),
  .stop_release_reset(stop_release_reset), .stop_release_ext(stop_release_ext),
  .osc_enable(osc_enable), .cpu_clock_enable(cpu_clock_enable),
  .watchdog_reset(watchdog_reset), .timer0_pwm_out(timer0_pwm_out),
  .timer0_overflow_irq(timer0_overflow_irq), .timer0_overflow_ack(timer0_overflow_ack),
  .timer0_match_capture_irq(timer0_match_capture_irq),
  .timer0_overflow_vector(timer0_overflow_vector), .timer0_match_vector(timer0_match_vector));
`default_nettype wire

// ==== verification/wt_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module wt_timer_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic stop_enter = 1'b0;
  logic stop_release_ext = 1'b0;
  logic stop_release_reset = 1'b0;
  logic ext_clk = 1'b0;
  logic cap_in = 1'b0;
  logic ovf_ack = 1'b0;
  wire [7:0] rdata;
  wire osc_en, cpu_en, wd_rst, pwm, ovf_irq, mc_irq;
  wire [7:0] vec_o, vec_m;
  int mismatches = 0;
  int n_checks = 0;
  int wd_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 50 ns period
  always #25 clk = ~clk;
  always @(posedge clk) if (wd_rst === 1'b1) wd_cnt++;
  wt_timer wt_timer_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata), .stop_enter(stop_enter),
    .stop_release_reset(stop_release_reset), .stop_release_ext(stop_release_ext),
    .osc_enable(osc_en), .cpu_clock_enable(cpu_en), .watchdog_reset(wd_rst),
    .timer0_ext_clock_in(ext_clk),
    .timer0_capture_in(cap_in), .timer0_pwm_out(pwm), .timer0_overflow_irq(ovf_irq),
    .timer0_overflow_ack(ovf_ack), .timer0_match_capture_irq(mc_irq),
    .timer0_overflow_vector(vec_o), .timer0_match_vector(vec_m));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    begin
      n_checks++;
      if (g !== e) begin
        mismatches++;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
    end
  endtask
  // read answer lands one cycle after the strobe is driven
  task rd(input logic [7:0] a, input logic [7:0] e);
    begin
      @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  function logic sig(input int s);
    case (s)
      0: return mc_irq;
      1: return ovf_irq;
      2: return wd_rst;
      default: return cpu_en;
    endcase
  endfunction
  // bounded wait; a run-out counts and closes the run
  task waitc(input int s, input logic v, input int lim);
    int i;
    begin
      // step off the edge so a value launched there is settled
      #1;
      for (i = 0; i < lim && sig(s) !== v; i++) begin @(posedge clk); #1; end
      chk({7'h0, sig(s)}, {7'h0, v});
      if (sig(s) !== v) end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rd(8'hd3, 8'h00);
      rd(8'hd2, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'hd3, 8'h52);
      rd(8'hd3, 8'h50);
      wr(8'hfd, 8'h33);
      rd(8'hfd, 8'h00);
    end
  endtask
  task t_interval;
    logic p;
    begin
      wr(8'hd1, 8'h03);
      wr(8'hd2, 8'h8a);
      waitc(0, 1'b1, 40);
      rd(8'hd2, 8'h83);
      p = pwm;
      wr(8'hd2, 8'h82);
      waitc(0, 1'b0, 3);
      waitc(0, 1'b1, 40);
      chk({7'h0, pwm}, {7'h0, ~p});
    end
  endtask
  task t_pwm;
    begin
      chk(vec_o, 8'hfa);
      chk(vec_m, 8'hfc);
      wr(8'hd1, 8'h80);
      wr(8'hd2, 8'hbc);
      waitc(1, 1'b1, 2100);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, pwm}, 8'h01);
      @(posedge clk) ovf_ack <= 1'b1;
      @(posedge clk) ovf_ack <= 1'b0;
      waitc(1, 1'b0, 2);
      repeat (1100) @(posedge clk);
      #1 chk({7'h0, pwm}, 8'h00);
    end
  endtask
  task t_cap;
    begin
      wr(8'hef, 8'h00);
      // external timer clock, capture on rising edge, counter cleared
      wr(8'hd2, 8'hda);
      @(posedge clk) cap_in <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk({7'h0, mc_irq}, 8'h00);
      @(posedge clk) cap_in <= 1'b0;
      wr(8'hef, 8'h04);
      // three external clock edges bring the counter to 3
      repeat (3) begin
        @(posedge clk) ext_clk <= 1'b1;
        @(posedge clk) ext_clk <= 1'b0;
      end
      @(posedge clk) cap_in <= 1'b1;
      waitc(0, 1'b1, 5);
      rd(8'hd1, 8'h03);
      rd(8'hd0, 8'h03);
      wr(8'hd2, 8'ha2);
      waitc(0, 1'b0, 3);
      @(posedge clk) cap_in <= 1'b0;
      waitc(0, 1'b1, 5);
    end
  endtask
  // bt at /128: 16 ticks of stabilization, 2048 clocks
  task t_stop;
    begin
      wr(8'hd3, 8'haa);
      @(posedge clk) stop_enter <= 1'b1;
      @(posedge clk) stop_enter <= 1'b0;
      #1 chk({6'h0, osc_en, cpu_en}, 8'h00);
      repeat (50) @(posedge clk);
      @(posedge clk) stop_release_ext <= 1'b1;
      @(posedge clk) stop_release_ext <= 1'b0;
      repeat (1500) @(posedge clk);
      #1 chk({6'h0, osc_en, cpu_en}, 8'h02);
      waitc(3, 1'b1, 800);
      // release by reset ignores the preset /128 and runs at /4096
      @(posedge clk) stop_enter <= 1'b1;
      @(posedge clk) stop_enter <= 1'b0;
      repeat (50) @(posedge clk);
      @(posedge clk) stop_release_reset <= 1'b1;
      @(posedge clk) stop_release_reset <= 1'b0;
      repeat (2500) @(posedge clk);
      #1 chk({6'h0, osc_en, cpu_en}, 8'h02);
      // reset in mid-run ends the long stabilization and restores defaults
      @(posedge clk) sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk({6'h0, osc_en, cpu_en}, 8'h03);
      rd(8'hd3, 8'h00);
      rd(8'hd2, 8'h00);
    end
  endtask
  // a cleared counter must outlive its uncleared overflow time
  task t_wd;
    int c;
    begin
      wr(8'hd3, 8'h5a);
      repeat (20000) @(posedge clk);
      wr(8'hd3, 8'h5a);
      c = wd_cnt;
      repeat (30000) @(posedge clk);
      chk(8'(wd_cnt - c), 8'h00);
      waitc(2, 1'b1, 4000);
      wr(8'hd3, 8'haa);
      c = wd_cnt;
      repeat (33500) @(posedge clk);
      chk(8'(wd_cnt - c), 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_interval;
    t_pwm;
    t_cap;
    t_stop;
    t_wd;
    end_of_test;
  end
endmodule
`default_nettype wire
